// ### hdl/rwcm_pkg.sv
// Purpose: Shared constants and types for the reset, watchdog and clock monitor unit
// Assumes: Bus clock of 250 MHz, one clock domain
// Notes: Long watchdog counts are sized by a top-level parameter, not here
package rwcm_pkg;
    // Bus clock rate
    localparam int unsigned CLK_KHZ = 250000;
    // Pull-low length on the reset pin, in bus cycles
    localparam logic [2:0] DRIVE_CYCLES = 3'h4;
    // Delay from release to sampling, in bus cycles
    localparam logic [2:0] SAMPLE_DELAY_CYCLES = 3'h2;
    // Sequence counter width
    localparam int unsigned SEQ_CNT_W = 3;
    // Window after reset in which the rate field may be written
    localparam logic [6:0] RATE_WINDOW_CYCLES = 7'h40;
    // Rate field after reset: shortest timeout
    localparam logic [1:0] RATE_RESET = 2'h0;
    // Default log2 of the watchdog base prescaler
    localparam int unsigned WDOG_PRESC_LOG2 = 15;
    // Last tick index for dividers 1, 4, 16 and 64
    localparam logic [5:0] TICK_LAST_DIV1 = 6'h00;
    localparam logic [5:0] TICK_LAST_DIV4 = 6'h03;
    localparam logic [5:0] TICK_LAST_DIV16 = 6'h0F;
    localparam logic [5:0] TICK_LAST_DIV64 = 6'h3F;
    // Service values: arming then closing
    localparam logic [7:0] SVC_ARM = 8'h55;
    localparam logic [7:0] SVC_CLOSE = 8'hAA;
    // Clock monitor limits and reference period
    localparam int unsigned CM_FAIL_KHZ = 10;
    localparam int unsigned CM_PASS_KHZ = 200;
    localparam int unsigned CM_REF_PERIOD_US = 1000;
    // Bus cycles per reference period at the failing limit
    localparam int unsigned CM_MIN_CYCLES_INT = CM_FAIL_KHZ * CM_REF_PERIOD_US / 1000;
    localparam int unsigned CM_CNT_W = 16;
    localparam logic [15:0] CM_MIN_CYCLES = CM_MIN_CYCLES_INT[15:0];
    // Reset sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DRIVE = 2'b01,
        ST_WAIT = 2'b10,
        ST_HOLD = 2'b11
    } seq_state_type;
endpackage

// ### hdl/reset_watchdog_clock_monitor.sv
// Purpose: Reset sequencer with reset pin, watchdog timer and clock monitor
// Assumes: All inputs synchronous to core_clk_i; pin level is a clean input
// Notes: Pin drive is split into level, enable and sensed level
`timescale 1ns/1ps
module reset_watchdog_clock_monitor #(
    parameter int unsigned PRESC_LOG2 = rwcm_pkg::WDOG_PRESC_LOG2
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic por_i,
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    output logic sys_rst_b_o,
    input wire logic watchdog_disable_bit_i,
    input wire logic special_mode_i,
    input wire logic rate_wr_i,
    input wire logic watchdog_rate_sel_hi_i,
    input wire logic watchdog_rate_sel_lo_i,
    input wire logic svc_wr_i,
    input wire logic [7:0] watchdog_service_register_i,
    input wire logic clock_monitor_enable_i,
    input wire logic stop_mode_i,
    input wire logic ref_tick_i,
    output logic [1:0] watchdog_rate_o,
    output logic watchdog_armed_o,
    output logic cause_ext_o,
    output logic cause_por_o,
    output logic cause_wdog_o,
    output logic cause_clkmon_o
);
    // Sequencer state and its step counter
    rwcm_pkg::seq_state_type state;
    rwcm_pkg::seq_state_type next_state;
    logic [rwcm_pkg::SEQ_CNT_W-1:0] seq_cnt;
    // Sources seen when the sequence began
    // Kept apart from the cause flags, which change only at sampling
    logic pend_por;
    logic pend_wdog;
    logic pend_cm;
    // Watchdog prescaler and timeout tick counter
    // Prescaler width follows the parameter; benches may shorten it
    logic [PRESC_LOG2-1:0] presc_cnt;
    logic [5:0] tick_cnt;
    // Rate lock window after reset
    // Counter stops at the window end so it never reopens the window
    logic [6:0] rate_cnt;
    logic rate_written;
    // Clock monitor measurement
    logic [rwcm_pkg::CM_CNT_W-1:0] cm_cnt;
    logic cm_valid;

    // Decoded conditions
    // Plain decodes as named wires; the registers below stay short
    wire in_idle = (state == rwcm_pkg::ST_IDLE);
    wire drive_done = (seq_cnt == rwcm_pkg::DRIVE_CYCLES - 3'h1);
    wire sample_now = (seq_cnt == rwcm_pkg::SAMPLE_DELAY_CYCLES - 3'h1);
    wire wdog_on = ~watchdog_disable_bit_i;
    wire wdog_run = wdog_on & in_idle;
    wire presc_wrap = &presc_cnt;
    // last tick index per rate code
    // Code three falls to the last arm, the largest divider
    wire [5:0] tick_last = (watchdog_rate_o == 2'h0) ? rwcm_pkg::TICK_LAST_DIV1 :
                           (watchdog_rate_o == 2'h1) ? rwcm_pkg::TICK_LAST_DIV4 :
                           (watchdog_rate_o == 2'h2) ? rwcm_pkg::TICK_LAST_DIV16 :
                           rwcm_pkg::TICK_LAST_DIV64;
    // Expiry needs the last tick and a prescaler wrap in one cycle
    wire wdog_expire = wdog_run & presc_wrap & (tick_cnt == tick_last);
    // closing value counts only after arming
    wire svc_close = svc_wr_i & (watchdog_service_register_i == rwcm_pkg::SVC_CLOSE)
                     & watchdog_armed_o;
    wire svc_arm = svc_wr_i & (watchdog_service_register_i == rwcm_pkg::SVC_ARM);
    // writes only inside window, once, unless special mode
    wire rate_ok = rate_wr_i & (special_mode_i |
                   (~rate_written & (rate_cnt < rwcm_pkg::RATE_WINDOW_CYCLES)));
    // too few bus cycles per reference period
    wire cm_slow = ref_tick_i & cm_valid & (cm_cnt < rwcm_pkg::CM_MIN_CYCLES);
    // stop halts clocks, so enabled stop fails
    wire cm_fail = clock_monitor_enable_i & in_idle & (cm_slow | stop_mode_i);
    // Sources seen mid-sequence start nothing and are not queued; only power-on is kept, as a cause
    // any of the four sources starts the sequence
    wire start_seq = por_i | ~reset_pin_i | wdog_expire | cm_fail;

    // Sequencer next state
    // Wait and hold read the pin; idle treats it as one more source
    always_comb begin
        next_state = state;
        case (state)
            rwcm_pkg::ST_IDLE: begin
                // Idle until a source appears
                if (start_seq) begin
                    next_state = rwcm_pkg::ST_DRIVE;
                end
            end
            rwcm_pkg::ST_DRIVE: begin
                if (drive_done) begin
                    next_state = rwcm_pkg::ST_WAIT;
                end
            end
            rwcm_pkg::ST_WAIT: begin
                if (sample_now) begin
                    next_state = reset_pin_i ? rwcm_pkg::ST_IDLE : rwcm_pkg::ST_HOLD;
                end
            end
            rwcm_pkg::ST_HOLD: begin
                // stay in reset until pin high
                if (reset_pin_i) begin
                    next_state = rwcm_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = rwcm_pkg::ST_DRIVE;
            end
        endcase
    end

    // Pin drive and internal reset follow the next state
    wire next_oe = (next_state == rwcm_pkg::ST_DRIVE);
    // reset held until sequence back to idle
    wire next_sys_rst_b = (next_state == rwcm_pkg::ST_IDLE);
    // Step counter restarts on every state change
    // It may wrap while holding; hold does not decode it
    wire [rwcm_pkg::SEQ_CNT_W-1:0] next_seq_cnt =
        (next_state != state) ? '0 : seq_cnt + 3'h1;

    // Sequencer registers; reset begins a power-on sequence
    // Reset enters the drive phase so every start looks like power-on
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state <= rwcm_pkg::ST_DRIVE;
            seq_cnt <= '0;
            reset_pin_oe_o <= 1'b1;
            sys_rst_b_o <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            seq_cnt <= next_seq_cnt;
            reset_pin_oe_o <= next_oe;
            sys_rst_b_o <= next_sys_rst_b;
        end
    end

    // Pin only ever drives low; the enable decides
    // Never driving high avoids a fight with outside reset circuitry
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            reset_pin_o <= 1'b0;
        end else if (ce_i) begin
            reset_pin_o <= 1'b0;
        end
    end

    // Record which internal sources opened the sequence
    // Overwritten when a sequence opens; a late power-on is added, so causes may mix
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            pend_por <= 1'b1;
            pend_wdog <= 1'b0;
            pend_cm <= 1'b0;
        end else if (ce_i) begin
            if (in_idle && start_seq) begin
                // watchdog expiry gets its own flag, not the pin path
                pend_por <= por_i;
                pend_wdog <= wdog_expire;
                pend_cm <= cm_fail;
            end else if (por_i) begin
                // Late power-on still counts as cause
                pend_por <= 1'b1;
            end
        end
    end

    // cause flags latched at the sampling point
    // Flags stand until the next sample for startup code to read
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cause_ext_o <= 1'b0;
            cause_por_o <= 1'b1;
            cause_wdog_o <= 1'b0;
            cause_clkmon_o <= 1'b0;
        end else if (ce_i) begin
            if (state == rwcm_pkg::ST_WAIT && sample_now) begin
                cause_ext_o <= ~reset_pin_i;
                cause_por_o <= pend_por;
                cause_wdog_o <= pend_wdog;
                cause_clkmon_o <= pend_cm;
            end
        end
    end

    // Watchdog prescaler and ticks; cleared in reset or on service
    // Parked at zero whenever the watchdog is off or in reset
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            presc_cnt <= '0;
            tick_cnt <= 6'h00;
        end else if (ce_i) begin
            if (!wdog_run || svc_close) begin
                presc_cnt <= '0;
                tick_cnt <= 6'h00;
            end else begin
                // Sized step keeps the sum at prescaler width
                presc_cnt <= presc_cnt + PRESC_LOG2'(1);
                if (presc_wrap) begin
                    tick_cnt <= (tick_cnt == tick_last) ? 6'h00 : tick_cnt + 6'h01;
                end
            end
        end
    end

    // Service arming flag
    // Any internal reset drops arming, so a stale arming write cannot count
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            watchdog_armed_o <= 1'b0;
        end else if (ce_i) begin
            if (!in_idle) begin
                watchdog_armed_o <= 1'b0;
            end else if (svc_wr_i) begin
                // any other value drops the arming
                watchdog_armed_o <= svc_arm;
            end
        end
    end

    // Rate field with its write window; internal reset restores it
    // Trade-off: one window counter serves every reset cause alike
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            watchdog_rate_o <= rwcm_pkg::RATE_RESET;
            rate_cnt <= 7'h00;
            rate_written <= 1'b0;
        end else if (ce_i) begin
            if (!in_idle) begin
                watchdog_rate_o <= rwcm_pkg::RATE_RESET;
                rate_cnt <= 7'h00;
                rate_written <= 1'b0;
            end else begin
                // Window counter saturates at its end
                if (rate_cnt < rwcm_pkg::RATE_WINDOW_CYCLES) begin
                    rate_cnt <= rate_cnt + 7'h01;
                end
                if (rate_ok) begin
                    watchdog_rate_o <= {watchdog_rate_sel_hi_i, watchdog_rate_sel_lo_i};
                    rate_written <= 1'b1;
                end
            end
        end
    end

    // Clock monitor: bus cycles counted per reference period
    // Limitation: the threshold assumes the nominal reference period
    // The first period after enabling is partial, so it only arms the check.
    // A fully stopped clock cannot be seen by clocked logic; stop mode is used.
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cm_cnt <= '0;
            cm_valid <= 1'b0;
        end else if (ce_i) begin
            if (ref_tick_i) begin
                cm_cnt <= '0;
            end else if (~&cm_cnt) begin
                // Saturate so a long period never wraps low
                cm_cnt <= cm_cnt + 16'h0001;
            end
            // clearing enable before stop disarms check
            if (!clock_monitor_enable_i || !in_idle) begin
                cm_valid <= 1'b0;
            end else if (ref_tick_i) begin
                cm_valid <= 1'b1;
            end
        end
    end
endmodule

// ### verif/rwcm_chk.sv
// Purpose: Port assertions for the reset and watchdog unit
// Assumes: Clock enable held high by the bench
// Notes: Release and sample steps are named sequences
`timescale 1ns/1ps
module rwcm_chk (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic por_i,
    input wire logic reset_pin_i,
    input wire logic reset_pin_oe_o,
    input wire logic sys_rst_b_o,
    input wire logic rate_wr_i,
    input wire logic svc_wr_i,
    input wire logic [7:0] watchdog_service_register_i,
    input wire logic clock_monitor_enable_i,
    input wire logic stop_mode_i,
    input wire logic [1:0] watchdog_rate_o,
    input wire logic watchdog_armed_o,
    input wire logic cause_ext_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Drive released, then the sampling cycle
    sequence let_go_s;
        $fell(reset_pin_oe_o);
    endsequence
    sequence high_seen_s;
        let_go_s ##1 reset_pin_i;
    endsequence
    sequence low_seen_s;
        let_go_s ##1 !reset_pin_i;
    endsequence
    // Idle with a pin or power-on request pending
    wire idle_req = sys_rst_b_o && (por_i || !reset_pin_i);
    drive_four_a:
    assert property ($rose(reset_pin_oe_o) |-> reset_pin_oe_o[*4] ##1 !reset_pin_oe_o)
        else $error("pin drive length wrong");
    sample_gap_a:
    assert property (let_go_s |-> !sys_rst_b_o[*2])
        else $error("reset lifted before sampling");
    internal_cause_a:
    assert property (high_seen_s |=> sys_rst_b_o && !cause_ext_o)
        else $error("high pin not taken as internal");
    external_cause_a:
    assert property (low_seen_s |=> !sys_rst_b_o && cause_ext_o)
        else $error("low pin not taken as external");
    hold_low_a:
    assert property (!sys_rst_b_o && !reset_pin_oe_o && !reset_pin_i |=> !sys_rst_b_o)
        else $error("reset lifted while pin low");
    request_start_a:
    assert property (idle_req |=> reset_pin_oe_o && !sys_rst_b_o)
        else $error("request did not start sequence");
    stop_reset_a:
    assert property (sys_rst_b_o && clock_monitor_enable_i && stop_mode_i |=> reset_pin_oe_o)
        else $error("stop with monitor gave no reset");
    arm_track_a:
    assert property (sys_rst_b_o && svc_wr_i |=> !sys_rst_b_o ||
        watchdog_armed_o == ($past(watchdog_service_register_i) == rwcm_pkg::SVC_ARM))
        else $error("arming state wrong");
    rate_hold_a:
    assert property (sys_rst_b_o && !rate_wr_i |=> $stable(watchdog_rate_o) || !sys_rst_b_o)
        else $error("rate moved without write");
endmodule
bind reset_watchdog_clock_monitor rwcm_chk chk (.core_clk_i, .rst_b_i, .por_i, .reset_pin_i,
    .reset_pin_oe_o, .sys_rst_b_o, .rate_wr_i, .svc_wr_i, .watchdog_service_register_i,
    .clock_monitor_enable_i, .stop_mode_i, .watchdog_rate_o, .watchdog_armed_o, .cause_ext_o);

// ### verif/rwcm_pin_model.sv
// Purpose: Outside circuitry sharing the reset line
// Assumes: Pull-up on the line
// Notes: Slow mode lets the line rise one cycle late
`timescale 1ns/1ps
module rwcm_pin_model (
    input wire logic core_clk_i,
    input wire logic drive_oe_i,
    input wire logic drive_val_i,
    input wire logic slow_i,
    input wire logic [7:0] hold_i,
    input wire logic hold_go_i,
    output logic pin_o
);
    logic [7:0] hold_cnt = 8'h00; // Cycles the outside still pulls low
    logic lag = 1'b0; // Late release in slow mode
    always @(posedge core_clk_i) begin
        hold_cnt <= hold_go_i ? hold_i : hold_cnt - {7'h00, hold_cnt != 8'h00};
        lag <= slow_i & drive_oe_i;
    end
    assign pin_o = !((drive_oe_i && !drive_val_i) || hold_cnt != 8'h00 || lag);
endmodule

// ### verif/reset_watchdog_clock_monitor_bench.sv
// Purpose: Self-checking bench for the reset and watchdog unit
// Assumes: Watchdog prescaler shortened to 2^4 cycles
// Notes: Expected figures are integer models, never design outputs
`timescale 1ns/1ps
module reset_watchdog_clock_monitor_bench;
    localparam int PL = 4; // Short prescaler keeps the run brief
    logic core_clk = 1'b0, rst_b = 1'b0, por = 1'b0, wdis = 1'b1, smode = 1'b0, rwr = 1'b0;
    logic rhi = 1'b0, rlo = 1'b0, swr = 1'b0, clock_monitor_enable = 1'b0, stop = 1'b0, tick = 1'b0;
    logic slow = 1'b0, go = 1'b0;
    logic [7:0] sdat = 8'h00, hold = 8'h00;
    logic pin, oe, pval, sys, armed, c_ext, c_por, c_wd, c_cm;
    logic [1:0] rate;
    int n_fail = 0, check_count = 0, k, n;
    always #2 core_clk = ~core_clk;
    rwcm_pin_model pm (.core_clk_i(core_clk), .drive_oe_i(oe), .drive_val_i(pval),
        .slow_i(slow), .hold_i(hold), .hold_go_i(go), .pin_o(pin));
    reset_watchdog_clock_monitor #(.PRESC_LOG2(PL)) uut (.core_clk_i(core_clk), .rst_b_i(rst_b),
        .ce_i(1'b1), .por_i(por), .reset_pin_i(pin), .reset_pin_o(pval), .reset_pin_oe_o(oe),
        .sys_rst_b_o(sys), .watchdog_disable_bit_i(wdis), .special_mode_i(smode),
        .rate_wr_i(rwr), .watchdog_rate_sel_hi_i(rhi), .watchdog_rate_sel_lo_i(rlo),
        .svc_wr_i(swr), .watchdog_service_register_i(sdat), .clock_monitor_enable_i(clock_monitor_enable),
        .stop_mode_i(stop), .ref_tick_i(tick), .watchdog_rate_o(rate),
        .watchdog_armed_o(armed), .cause_ext_o(c_ext), .cause_por_o(c_por),
        .cause_wdog_o(c_wd), .cause_clkmon_o(c_cm));
    task automatic chk(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %b want %b", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge core_clk);
    endtask
    // Bounded wait for pin drive or reset lift
    task automatic wait_for(input bit want_oe);
        k = 0;
        while ((want_oe ? oe : sys) !== 1'b1 && k < 4000) begin
            cyc(1);
            k++;
        end
        if (k == 4000) begin
            n_fail++;
            $display("BAD t=%0t wait ran out", $time);
        end
    endtask
    task automatic svc(input logic [7:0] v);
        {swr, sdat} = {1'b1, v};
        cyc(1);
        swr = 1'b0;
        // Gap cycle so a following call never re-raises the strobe at once
        cyc(1);
    endtask
    task automatic rwrite(input logic [1:0] c);
        {rwr, rhi, rlo} = {1'b1, c};
        cyc(1);
        rwr = 1'b0;
        // Gap cycle so a following call never re-raises the strobe at once
        cyc(1);
    endtask
    task automatic tk(input int g);
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        cyc(g - 1);
    endtask
    initial begin
        void'($urandom(74014));
        cyc(5);
        rst_b = 1'b1;
        wait_for(0);
        chk(c_por, 1'b1);
        chk(c_ext, 1'b0);
        {hold, go, por} = {8'h28, 2'b11};
        cyc(1);
        {go, por} = 2'b00;
        cyc(30);
        chk(sys, 1'b0);
        chk(c_ext & c_por, 1'b1);
        wait_for(0);
        {hold, go} = {8'h08, 1'b1};
        cyc(1);
        go = 1'b0;
        // Reset output is still high here; wait for the drive first
        wait_for(1);
        wait_for(0);
        chk(c_ext & !c_por, 1'b1);
        $display("pin and power-on tests done");
        slow = 1'b1;
        repeat (3) tk(3);
        chk(oe, 1'b0);
        clock_monitor_enable = 1'b1;
        repeat (3) tk(11);
        chk(oe, 1'b0);
        tk(7);
        tk(2);
        wait_for(1);
        chk(k < 4, 1'b1);
        wait_for(0);
        chk(c_cm & !c_ext, 1'b1);
        stop = 1'b1;
        cyc(2);
        chk(oe, 1'b1);
        chk(pval, 1'b0);
        {stop, clock_monitor_enable} = 2'b00;
        wait_for(0);
        stop = 1'b1;
        cyc(20);
        chk(oe, 1'b0);
        stop = 1'b0;
        $display("clock monitor tests done");
        wdis = 1'b0;
        wait_for(1);
        wait_for(0);
        for (int c = 0; c < 4; c++) begin
            chk(c_wd & (rate == 2'h0), 1'b1);
            rwrite(2'(c));
            rwrite(2'(~c));
            chk(rate == 2'(c), 1'b1);
            wait_for(1);
            n = (1 << (2 * c)) << PL;
            chk(k + 4 >= n - (1 << PL) && k + 4 <= n + (1 << PL) + 8, 1'b1);
            wait_for(0);
        end
        $display("watchdog rate tests done");
        rwrite(2'h1);
        repeat (6) begin
            cyc(1 + $urandom % 15);
            svc(8'h55);
            chk(armed, 1'b1);
            cyc(1 + $urandom % 15);
            svc(8'hAA);
            chk(armed, 1'b0);
        end
        chk(oe, 1'b0);
        rwrite(2'h3);
        chk(rate == 2'h1, 1'b1);
        // Special mode reopens the field after the window
        smode = 1'b1;
        rwrite(2'h3);
        chk(rate == 2'h3, 1'b1);
        rwrite(2'h1);
        smode = 1'b0;
        chk(rate == 2'h1, 1'b1);
        svc(8'hAA);
        svc(8'h55);
        svc(8'h56 + 8'($urandom % 80));
        chk(armed, 1'b0);
        svc(8'hAA);
        wait_for(1);
        chk(k + 15 >= 48 && k + 15 <= 88, 1'b1);
        wait_for(0);
        chk(c_wd, 1'b1);
        wdis = 1'b1;
        $display("watchdog service tests done");
        close_out();
    end
    initial begin
        #200000;
        n_fail++;
        $display("BAD t=%0t run limit reached", $time);
        close_out();
    end
endmodule
